// ===== nvram_cmd_pkg.sv
// Shared constants, field positions and carrier types for the command handler.
package nvram_cmd_pkg;

    // ==========================================================
    // Report geometry
    localparam int REPORT_BYTES = 64;
    localparam int IDX_W = 6;
    localparam int CS_LINES = 9;

    // ==========================================================
    // Command, sub-command and status codes
    localparam logic [7:0] CMD_SET_NV = 8'h60;
    localparam logic [7:0] CMD_GET_NV = 8'h61;
    localparam logic [7:0] SUB_SPI = 8'h10;
    localparam logic [7:0] SUB_KEY = 8'h30;
    localparam logic [7:0] SUB_PROD = 8'h40;
    localparam logic [7:0] SUB_MANUF = 8'h50;
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_BLOCKED = 8'hFB;
    localparam logic [7:0] ST_BUSY = 8'hF8;
    localparam logic [7:0] ST_UNSUPPORTED = 8'hFF;

    // ==========================================================
    // Access control settings
    localparam logic [7:0] ACC_OPEN = 8'h00;
    localparam logic [7:0] ACC_PASSWORD = 8'h40;
    localparam logic [7:0] ACC_LOCKED = 8'h80;

    // ==========================================================
    // Byte positions inside a report
    localparam logic [5:0] POS_CMD = 6'h00;
    localparam logic [5:0] POS_SUB = 6'h01;
    localparam logic [5:0] POS_ECHO = 6'h02;
    localparam logic [5:0] POS_RATE = 6'h04;
    localparam logic [5:0] POS_IDLE_CS = 6'h08;
    localparam logic [5:0] POS_ACT_CS = 6'h0A;
    localparam logic [5:0] POS_DLY_PRE = 6'h0C;
    localparam logic [5:0] POS_DLY_POST = 6'h0E;
    localparam logic [5:0] POS_DLY_GAP = 6'h10;
    localparam logic [5:0] POS_XFER_LEN = 6'h12;
    localparam logic [5:0] POS_MODE = 6'h14;
    localparam logic [5:0] POS_VID = 6'h04;
    localparam logic [5:0] POS_PID = 6'h06;
    localparam logic [5:0] POS_POWER = 6'h08;
    localparam logic [5:0] POS_CURRENT = 6'h09;
    localparam logic [5:0] POS_STR_FIRST = 6'h04;
    localparam logic [5:0] POS_LAST = 6'h3F;

    // ==========================================================
    // Field layouts, units and masks
    localparam logic [15:0] CS_MASK = 16'h01FF;
    localparam logic [1:0] SPI_MODE_MASK = 2'h3;
    localparam logic [7:0] POWER_MASK = 8'hE0;
    localparam int PWR_HOST_BIT = 7;
    localparam int PWR_SELF_BIT = 6;
    localparam int PWR_WAKE_BIT = 5;
    localparam int DELAY_UNIT_US = 100;
    localparam int CURRENT_UNIT_MA = 2;

    // ==========================================================
    // Reset values of the stored settings
    localparam logic [31:0] RST_BIT_RATE = 32'h0000_1000;
    localparam logic [15:0] RST_IDLE_CS = 16'h01FF;
    localparam logic [15:0] RST_ACT_CS = 16'h0000;
    localparam logic [15:0] RST_DELAY = 16'h0000;
    localparam logic [15:0] RST_XFER_LEN = 16'h0004;
    localparam logic [1:0] RST_SPI_MODE = 2'h0;
    localparam logic [15:0] RST_VID = 16'h1234;
    localparam logic [15:0] RST_PID = 16'h5678;
    localparam logic [7:0] RST_POWER = 8'h80;
    localparam logic [7:0] RST_CURRENT = 8'h32;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [31:0] bit_rate;
        logic [15:0] idle_cs;
        logic [15:0] active_cs;
        logic [15:0] dly_pre;
        logic [15:0] dly_post;
        logic [15:0] dly_gap;
        logic [15:0] xfer_len;
        logic [1:0] mode;
    } spi_cfg_t;

    typedef struct packed {
        logic [15:0] vid;
        logic [15:0] pid;
        logic [7:0] power;
        logic [7:0] current;
    } usb_key_t;

    typedef struct packed {
        logic we;
        logic product;
        logic [5:0] addr;
        logic [7:0] data;
    } str_wr_t;

    typedef enum logic [3:0] {
        S_RECV = 4'h1,
        S_EXEC = 4'h2,
        S_STR = 4'h4,
        S_SEND = 4'h8
    } state_t;

endpackage

// ===== report_capture.sv
// Byte counter that frames the incoming request report.
`timescale 1ns/100ps
module report_capture import nvram_cmd_pkg::*; #(
    parameter int BYTES = REPORT_BYTES
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset.
    input wire logic i_enable, // Handler ready for bytes.
    input wire logic i_valid, // Request byte valid.
    output logic o_wr, // Byte taken this cycle.
    output logic [IDX_W-1:0] o_idx, // Position of the byte taken.
    output logic o_done // Last byte of the report taken.
);
    logic [IDX_W-1:0] count;

    generate
        if (BYTES != (1 << IDX_W)) begin : g_bad_size
            $error("report size must fill the index width");
        end
    endgenerate

    assign o_wr = i_enable & i_valid;
    assign o_idx = count;
    assign o_done = o_wr && (count == IDX_W'(BYTES - 1));

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count <= '0;
        end else if (o_wr) begin
            count <= o_done ? '0 : IDX_W'(count + 1'b1);
        end
    end
endmodule

// ===== reply_sender.sv
// Serialiser that streams one response report with valid and ready.
`timescale 1ns/100ps
module reply_sender import nvram_cmd_pkg::*; #(
    parameter int BYTES = REPORT_BYTES
) (
    input wire logic i_clk, // System clock.
    input wire logic i_rst, // Synchronous reset.
    input wire logic i_start, // Begin a report.
    input wire logic [7:0] i_byte, // Byte at o_rd_idx.
    input wire logic i_ready, // Receiver takes the byte.
    output logic [IDX_W-1:0] o_rd_idx, // Byte to fetch next.
    output logic o_valid, // Response byte valid.
    output logic [7:0] o_data, // Response byte.
    output logic o_done // Last byte taken, one cycle.
);
    logic [IDX_W-1:0] idx;
    logic last;

    generate
        if (BYTES != (1 << IDX_W)) begin : g_bad_size
            $error("report size must fill the index width");
        end
    endgenerate

    assign last = (idx == IDX_W'(BYTES - 1));
    assign o_rd_idx = i_start ? '0 : IDX_W'(idx + 1'b1);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            idx <= '0;
            o_valid <= 1'b0;
            o_data <= 8'h00;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                idx <= '0;
                o_valid <= 1'b1;
                o_data <= i_byte;
            end else if (o_valid && i_ready) begin
                if (last) begin
                    o_valid <= 1'b0;
                    o_done <= 1'b1;
                end else begin
                    idx <= o_rd_idx;
                    o_data <= i_byte;
                end
            end
        end
    end
endmodule

// ===== nvram_settings_command_handler.sv
// Command interpreter for the power-up settings reports.
`timescale 1ns/100ps
//
// Behaviour
// - SPI mode at byte 20, values 0 to 3 select modes 0 to 3.
// - Blocked SPI settings write answers 0x60 then 0xFB.
// - SPI settings write during USB transfer: unwritten, 0xF8, echo 0x10.
// - Stored SPI settings answer 0x60, 0x00, echo 0x10.
// - Vendor id at bytes 4 and 5, product id at 6 and 7, low first.
// - Byte 8 power option: bit 7 host, 6 self, 5 wakeup, rest zero.
// - Byte 9 requested current in 2 mA units.
// - Key and string writes blocked answer 0xFB.
// - Key write success answers 0x60, 0x00, echo 0x30.
// - String byte 4 is twice the character count plus two.
// - String success answers 0x00 and echoes 0x50 or 0x40.
// - SPI settings read answers 0x61, 0x00, 0x10 and the fields.
// - Bit rate is 32 bits at bytes 4 to 7, low byte first.
// - Select patterns at bytes 8-9 and 10-11, nine lines.
// - Three 16-bit delays in 100 us units at bytes 12 to 17.
// - Transaction length 16 bits at bytes 18 and 19.
// - Access setting open, password or locked decides refusal.
module nvram_settings_command_handler import nvram_cmd_pkg::*; (
    input wire logic I_SYS_CLK, // System clock, 100 MHz.
    input wire logic I_RST, // Synchronous reset, active high.
    input wire logic I_RX_VALID, // Request byte valid.
    input wire logic [7:0] I_RX_DATA, // Request byte.
    output logic O_RX_READY, // Handler takes request bytes.
    output logic O_TX_VALID, // Response byte valid.
    output logic [7:0] O_TX_DATA, // Response byte.
    input wire logic I_TX_READY, // Response byte taken.
    input wire logic [7:0] I_ACCESS_MODE, // Stored access setting.
    input wire logic I_PASSWORD_OK, // Password has been supplied.
    input wire logic I_USB_XFER_BUSY, // USB-started transfer running.
    output spi_cfg_t O_SPI_CFG, // Stored SPI settings.
    output usb_key_t O_USB_KEY, // Stored USB key settings.
    output str_wr_t O_STR_WR // String descriptor byte write.
);
    // ==========================================================
    // Request capture
    logic [7:0] req [REPORT_BYTES];
    logic cap_wr;
    logic cap_done;
    logic [IDX_W-1:0] cap_idx;
    state_t state;

    report_capture #(.BYTES(REPORT_BYTES)) u_capture (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_enable(O_RX_READY),
        .i_valid(I_RX_VALID),
        .o_wr(cap_wr),
        .o_idx(cap_idx),
        .o_done(cap_done)
    );

    always_ff @(posedge I_SYS_CLK) begin
        if (cap_wr) begin
            req[cap_idx] <= I_RX_DATA;
        end
    end

    // ==========================================================
    // Request decode
    logic [7:0] cmd;
    logic [7:0] sub;
    logic is_set;
    logic is_get_spi;
    logic blocked;
    logic set_spi_ok;
    logic set_key_ok;
    logic set_str_ok;
    logic refused;

    assign cmd = req[POS_CMD];
    assign sub = req[POS_SUB];
    assign is_set = (cmd == CMD_SET_NV) && ((sub == SUB_SPI)
        || (sub == SUB_KEY) || (sub == SUB_PROD) || (sub == SUB_MANUF));
    assign is_get_spi = (cmd == CMD_GET_NV) && (sub == SUB_SPI);
    // access setting gate
    // Unknown access values are treated as locked, the safe reading.
    assign blocked = (I_ACCESS_MODE == ACC_PASSWORD) ? !I_PASSWORD_OK
        : (I_ACCESS_MODE != ACC_OPEN);
    assign set_spi_ok = is_set && (sub == SUB_SPI) && !blocked
        && !I_USB_XFER_BUSY;
    assign set_key_ok = is_set && (sub == SUB_KEY) && !blocked;
    assign set_str_ok = is_set && ((sub == SUB_PROD)
        || (sub == SUB_MANUF)) && !blocked;
    assign refused = is_set && !set_spi_ok && !set_key_ok && !set_str_ok;

    // ==========================================================
    // Sequencing
    logic [5:0] str_idx;
    logic send_start;
    logic send_done;
    logic [IDX_W-1:0] rd_idx;
    logic [7:0] rd_byte;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            state <= S_RECV;
            O_RX_READY <= 1'b1;
            send_start <= 1'b0;
        end else begin
            send_start <= 1'b0;
            case (state)
                S_RECV: begin
                    if (cap_done) begin
                        state <= S_EXEC;
                        O_RX_READY <= 1'b0;
                    end
                end
                S_EXEC: begin
                    if (set_str_ok) begin
                        state <= S_STR;
                    end else begin
                        state <= S_SEND;
                        send_start <= 1'b1;
                    end
                end
                S_STR: begin
                    if (str_idx == POS_LAST) begin
                        state <= S_SEND;
                        send_start <= 1'b1;
                    end
                end
                S_SEND: begin
                    if (send_done) begin
                        state <= S_RECV;
                        O_RX_READY <= 1'b1;
                    end
                end
                default: begin
                    state <= S_RECV;
                    O_RX_READY <= 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Response header
    logic [7:0] rsp_cmd;
    logic [7:0] rsp_status;
    logic [7:0] rsp_sub;
    logic rsp_get;

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            rsp_cmd <= 8'h00;
            rsp_status <= ST_OK;
            rsp_sub <= 8'h00;
            rsp_get <= 1'b0;
        end else if (state == S_EXEC) begin
            rsp_cmd <= cmd;
            rsp_sub <= sub;
            rsp_get <= is_get_spi;
            if (is_set && blocked) begin
                rsp_status <= ST_BLOCKED;
            end else if (is_set && (sub == SUB_SPI) && I_USB_XFER_BUSY) begin
                rsp_status <= ST_BUSY;
            end else if (is_set || is_get_spi) begin
                rsp_status <= ST_OK;
            end else begin
                rsp_status <= ST_UNSUPPORTED;
            end
        end
    end

    // ==========================================================
    // Stored SPI settings
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_SPI_CFG.bit_rate <= RST_BIT_RATE;
            O_SPI_CFG.idle_cs <= RST_IDLE_CS;
            O_SPI_CFG.active_cs <= RST_ACT_CS;
            O_SPI_CFG.dly_pre <= RST_DELAY;
            O_SPI_CFG.dly_post <= RST_DELAY;
            O_SPI_CFG.dly_gap <= RST_DELAY;
            O_SPI_CFG.xfer_len <= RST_XFER_LEN;
            O_SPI_CFG.mode <= RST_SPI_MODE;
        end else if ((state == S_EXEC) && set_spi_ok) begin
            O_SPI_CFG.bit_rate <= {req[POS_RATE + 6'h03],
                req[POS_RATE + 6'h02], req[POS_RATE + 6'h01],
                req[POS_RATE]};
            O_SPI_CFG.idle_cs <= {req[POS_IDLE_CS + 6'h01],
                req[POS_IDLE_CS]} & CS_MASK;
            O_SPI_CFG.active_cs <= {req[POS_ACT_CS + 6'h01],
                req[POS_ACT_CS]} & CS_MASK;
            O_SPI_CFG.dly_pre <= {req[POS_DLY_PRE + 6'h01],
                req[POS_DLY_PRE]};
            O_SPI_CFG.dly_post <= {req[POS_DLY_POST + 6'h01],
                req[POS_DLY_POST]};
            O_SPI_CFG.dly_gap <= {req[POS_DLY_GAP + 6'h01],
                req[POS_DLY_GAP]};
            O_SPI_CFG.xfer_len <= {req[POS_XFER_LEN + 6'h01],
                req[POS_XFER_LEN]};
            O_SPI_CFG.mode <= req[POS_MODE][1:0] & SPI_MODE_MASK;
        end
    end

    // ==========================================================
    // Stored USB key settings
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            O_USB_KEY.vid <= RST_VID;
            O_USB_KEY.pid <= RST_PID;
            O_USB_KEY.power <= RST_POWER;
            O_USB_KEY.current <= RST_CURRENT;
        end else if ((state == S_EXEC) && set_key_ok) begin
            O_USB_KEY.vid <= {req[POS_VID + 6'h01], req[POS_VID]};
            O_USB_KEY.pid <= {req[POS_PID + 6'h01], req[POS_PID]};
            // reserved power bits forced to zero
            O_USB_KEY.power <= req[POS_POWER] & POWER_MASK;
            O_USB_KEY.current <= req[POS_CURRENT];
        end
    end

    // ==========================================================
    // String descriptor writes
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RST) begin
            str_idx <= POS_STR_FIRST;
            O_STR_WR <= '0;
        end else if (state == S_STR) begin
            // length, type and characters stored as sent
            O_STR_WR.we <= 1'b1;
            O_STR_WR.product <= (sub == SUB_PROD);
            O_STR_WR.addr <= 6'(str_idx - POS_STR_FIRST);
            O_STR_WR.data <= req[str_idx];
            str_idx <= 6'(str_idx + 6'h01);
        end else begin
            str_idx <= POS_STR_FIRST;
            O_STR_WR.we <= 1'b0;
        end
    end

    // ==========================================================
    // Response serialiser
    // read answer carries the stored fields
    always_comb begin
        rd_byte = 8'h00;
        if (rd_idx == POS_CMD) begin
            rd_byte = rsp_cmd;
        end else if (rd_idx == POS_SUB) begin
            rd_byte = rsp_status;
        end else if (rd_idx == POS_ECHO) begin
            rd_byte = rsp_sub;
        end else if (rsp_get) begin
            case (rd_idx)
                POS_RATE: rd_byte = O_SPI_CFG.bit_rate[7:0];
                POS_RATE + 6'h01: rd_byte = O_SPI_CFG.bit_rate[15:8];
                POS_RATE + 6'h02: rd_byte = O_SPI_CFG.bit_rate[23:16];
                POS_RATE + 6'h03: rd_byte = O_SPI_CFG.bit_rate[31:24];
                POS_IDLE_CS: rd_byte = O_SPI_CFG.idle_cs[7:0];
                POS_IDLE_CS + 6'h01: rd_byte = O_SPI_CFG.idle_cs[15:8];
                POS_ACT_CS: rd_byte = O_SPI_CFG.active_cs[7:0];
                POS_ACT_CS + 6'h01: rd_byte = O_SPI_CFG.active_cs[15:8];
                POS_DLY_PRE: rd_byte = O_SPI_CFG.dly_pre[7:0];
                POS_DLY_PRE + 6'h01: rd_byte = O_SPI_CFG.dly_pre[15:8];
                POS_DLY_POST: rd_byte = O_SPI_CFG.dly_post[7:0];
                POS_DLY_POST + 6'h01: rd_byte = O_SPI_CFG.dly_post[15:8];
                POS_DLY_GAP: rd_byte = O_SPI_CFG.dly_gap[7:0];
                POS_DLY_GAP + 6'h01: rd_byte = O_SPI_CFG.dly_gap[15:8];
                POS_XFER_LEN: rd_byte = O_SPI_CFG.xfer_len[7:0];
                POS_XFER_LEN + 6'h01: rd_byte = O_SPI_CFG.xfer_len[15:8];
                POS_MODE: rd_byte = {6'h00, O_SPI_CFG.mode};
                default: rd_byte = 8'h00;
            endcase
        end
    end

    reply_sender #(.BYTES(REPORT_BYTES)) u_sender (
        .i_clk(I_SYS_CLK),
        .i_rst(I_RST),
        .i_start(send_start),
        .i_byte(rd_byte),
        .i_ready(I_TX_READY),
        .o_rd_idx(rd_idx),
        .o_valid(O_TX_VALID),
        .o_data(O_TX_DATA),
        .o_done(send_done)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RST);

    chk_mode_store: assert property (
        (state == S_EXEC) && set_spi_ok
        |=> O_SPI_CFG.mode == $past(req[POS_MODE][1:0]))
        else $error("SPI mode not stored from byte 20");
    chk_blocked_code: assert property (
        (state == S_EXEC) && is_set && blocked
        |=> (rsp_status == ST_BLOCKED) && (rsp_cmd == CMD_SET_NV))
        else $error("blocked write not answered with 0xFB");
    chk_busy_code: assert property (
        (state == S_EXEC) && is_set && !blocked && (sub == SUB_SPI)
        && I_USB_XFER_BUSY
        |=> (rsp_status == ST_BUSY) && (rsp_sub == SUB_SPI)
        && $stable(O_SPI_CFG))
        else $error("busy SPI write not refused with 0xF8");
    chk_spi_done: assert property (
        (state == S_EXEC) && set_spi_ok
        |=> (rsp_status == ST_OK) && (rsp_sub == SUB_SPI) && send_start)
        else $error("SPI write success answer wrong");
    chk_key_store: assert property (
        (state == S_EXEC) && set_key_ok
        |=> (O_USB_KEY.vid == {$past(req[POS_VID + 6'h01]),
        $past(req[POS_VID])}) && (rsp_sub == SUB_KEY))
        else $error("vendor id not stored low byte first");
    chk_power_zero: assert property (
        O_USB_KEY.power[4:0] == 5'h00)
        else $error("reserved power bits not zero");
    chk_refused_hold: assert property (
        (state == S_EXEC) && refused
        |=> $stable(O_SPI_CFG) && $stable(O_USB_KEY) ##1 !O_STR_WR.we)
        else $error("refused write changed stored settings");
    chk_get_header: assert property (
        (state == S_EXEC) && is_get_spi
        |=> (rsp_cmd == CMD_GET_NV) && (rsp_status == ST_OK)
        && rsp_get ##1 O_TX_VALID && (O_TX_DATA == CMD_GET_NV))
        else $error("SPI read answer header wrong");
    chk_one_reply: assert property (
        send_done |=> O_RX_READY && !O_TX_VALID)
        else $error("request port not reopened after answer");
    chk_no_overlap: assert property (
        O_TX_VALID |-> !O_RX_READY)
        else $error("answer sent while taking a request");
    chk_str_length: assert property (
        (state == S_STR) && (str_idx == POS_STR_FIRST)
        |=> O_STR_WR.we && (O_STR_WR.addr == 6'h00)
        && (O_STR_WR.data == req[POS_STR_FIRST]))
        else $error("string length byte not written first");
    chk_str_echo: assert property (
        (state == S_EXEC) && set_str_ok
        |=> (rsp_status == ST_OK) && (rsp_sub == $past(sub)))
        else $error("string write success answer wrong");
endmodule

// ===== host_model.sv
// Host model that sends one request report and collects the reply.
`timescale 1ns/100ps
module host_model (
    input wire logic i_clk, // Clock.
    input wire logic i_go, // Start.
    input wire logic [511:0] i_req, // Request.
    input wire logic i_rx_ready, // Bytes taken.
    input wire logic i_tx_valid, // Reply valid.
    input wire logic [7:0] i_tx_data, // Reply byte.
    output logic o_rx_valid, // Byte valid.
    output logic [7:0] o_rx_data, // Byte.
    output logic o_tx_ready, // Reply taken.
    output logic [511:0] o_resp, // Reply.
    output logic o_done // Finished.
);
    int n;
    int k;
    // ==========================================================
    // Exchange
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
        o_tx_ready = 1'b0;
        o_resp = '0;
        o_done = 1'b0;
        forever begin
            @(posedge i_clk);
            if (i_go) begin
                o_done <= 1'b0;
                for (n = 0; n < 64; n++) begin
                    o_rx_valid <= 1'b1;
                    o_rx_data <= i_req[8*n +: 8];
                    @(posedge i_clk);
                    for (k = 0; k < 300 && !i_rx_ready; k++) begin
                        @(posedge i_clk);
                    end
                end
                // Idle data is scrambled so a stale byte cannot pass.
                o_rx_valid <= 1'b0;
                o_rx_data <= ~o_rx_data;
                k = 0;
                for (n = 0; n < 400 && k < 64; n++) begin
                    @(posedge i_clk);
                    if (i_tx_valid && o_tx_ready) begin
                        o_resp[8*k +: 8] = i_tx_data;
                        k++;
                    end
                    o_tx_ready <= (k < 64) ? ~o_tx_ready : 1'b0;
                end
                // A cut reply leaves done low so the bench times out.
                if (k == 64) o_done <= 1'b1;
            end
        end
    end
endmodule

// ===== nvram_settings_command_handler_tb.sv
// Self-checking bench for the settings command handler.
`timescale 1ns/100ps
module nvram_settings_command_handler_tb import nvram_cmd_pkg::*; ();
    logic clk, rst, pw, busy, go, done, rxv, rxr, txv, txr, prod_seen;
    logic [7:0] acc, rxd, txd, len_seen;
    logic [511:0] req, resp, spi_req, r;
    spi_cfg_t spi_cfg, exp_cfg;
    usb_key_t usb_key;
    str_wr_t str_wr;
    int error_cnt, checked, we_cnt;
    nvram_settings_command_handler u_dut (.I_SYS_CLK(clk), .I_RST(rst),
        .I_RX_VALID(rxv), .I_RX_DATA(rxd), .O_RX_READY(rxr),
        .O_TX_VALID(txv), .O_TX_DATA(txd), .I_TX_READY(txr),
        .I_ACCESS_MODE(acc), .I_PASSWORD_OK(pw), .I_USB_XFER_BUSY(busy),
        .O_SPI_CFG(spi_cfg), .O_USB_KEY(usb_key), .O_STR_WR(str_wr));
    host_model u_host (.i_clk(clk), .i_go(go), .i_req(req),
        .i_rx_ready(rxr), .i_tx_valid(txv), .i_tx_data(txd),
        .o_rx_valid(rxv), .o_rx_data(rxd), .o_tx_ready(txr),
        .o_resp(resp), .o_done(done));
    always @(posedge clk) begin
        if (rst || go) begin
            we_cnt <= 0;
            len_seen <= 8'h00;
            prod_seen <= 1'b0;
        end else if (str_wr.we) begin
            we_cnt <= we_cnt + 1;
            prod_seen <= str_wr.product;
            if (str_wr.addr == 6'h00) len_seen <= str_wr.data;
        end
    end
    task automatic chk(input logic [159:0] s, input logic [159:0] e);
        checked++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d errors=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic xfer(input logic [511:0] q);
        req <= q;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int k = 0; k < 1000; k++) begin
            @(posedge clk);
            if (done === 1'b1) return;
        end
        error_cnt++;
        complete_run();
    endtask
    task automatic t_spi();
        for (int m = 0; m < 4; m++) begin
            spi_req[167:160] = 8'(m);
            exp_cfg.mode = 2'(m);
            xfer(spi_req);
            chk(resp[23:0], 24'h100060);
            chk(spi_cfg, exp_cfg);
        end
        xfer(512'h1061);
        chk(resp[23:0], 24'h100061);
        chk(resp[167:32], spi_req[167:32]);
        $display("test spi done");
    endtask
    task automatic t_refuse();
        r = spi_req;
        r[39:32] = 8'hFF;
        busy <= 1'b1;
        xfer(r);
        chk(resp[23:0], 24'h10F860);
        chk(spi_cfg, exp_cfg);
        busy <= 1'b0;
        acc <= 8'h80;
        xfer(r);
        chk(resp[15:0], 16'hFB60);
        chk(spi_cfg, exp_cfg);
        $display("test refuse done");
    endtask
    task automatic t_key();
        r = '0;
        r[79:0] = {8'h32, 8'h40, 16'hC3D4, 16'hA1B2, 32'h3060};
        acc <= 8'h40;
        pw <= 1'b0;
        xfer(r);
        chk(resp[15:0], 16'hFB60);
        chk(usb_key, {RST_VID, RST_PID, RST_POWER, RST_CURRENT});
        pw <= 1'b1;
        xfer(r);
        chk(resp[23:0], 24'h300060);
        chk(usb_key, {16'hA1B2, 16'hC3D4, 8'h40, 8'h32});
        $display("test key done");
    endtask
    task automatic t_str(input logic [7:0] sub);
        r = '0;
        r[63:0] = {16'h0041, 8'h03, 8'h04, 8'h00, 8'h00, sub, 8'h60};
        xfer(r);
        chk(resp[23:0], {sub, 16'h0060});
        chk(we_cnt, 60);
        chk(len_seen, 8'h04);
        chk(prod_seen, sub == SUB_PROD);
        $display("test string done");
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {pw, busy, go, acc, error_cnt, checked} = '0;
        rst = 1'b1;
        spi_req = '0;
        spi_req[159:0] = {16'h04E2, 16'h0009, 16'h0007, 16'h0005,
            16'h01AA, 16'h0155, 32'h00B71B00, 32'h1060};
        exp_cfg = {32'h00B71B00, 16'h0155, 16'h01AA, 16'h0005,
            16'h0007, 16'h0009, 16'h04E2, 2'h0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_spi();
        t_refuse();
        t_key();
        t_str(8'h50);
        t_str(8'h40);
        complete_run();
    end
endmodule
